// ==== pstp_properties.sv ====
// assertion checker for the processor status trace port
`timescale 1ns/1ps
module pstp_properties (
  // clock and reset
  input logic       aclk,
  input logic       aresetn,
  // pins and core side
  input logic       output_float_request_n,
  input logic       trst_n,
  input logic       scan_tdo_en,
  input logic       scan_mode,
  input logic       core_stopped,
  input logic       core_halted,
  input logic       capture_ready,
  input logic [1:0] capture_bytes_m1,
  // trace outputs
  input logic       status_clock_out,
  input logic       status_clock_oe,
  input logic [3:0] processor_status_code,
  input logic       processor_status_oe,
  input logic [3:0] debug_data_nibble,
  input logic       debug_data_oe,
  input logic       debug_serial_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // float is combinational, so no trace driver may survive a sampled float request
  a_float_all_off: assert property (!output_float_request_n |->
    !status_clock_oe && !processor_status_oe && !debug_data_oe) else $error("driver on in float");
  a_float_spares_scan: assert property (scan_mode && trst_n && scan_tdo_en |->
    debug_serial_oe) else $error("scan output floated");
  a_trst_floats_tdo: assert property (scan_mode && !trst_n |-> !debug_serial_oe)
    else $error("scan output driven in test reset");
  a_clock_toggles: assert property ($past(aresetn) |->
    status_clock_out != $past(status_clock_out)) else $error("status clock stuck");
  // trace buses move only together with the falling status clock
  a_code_on_fall: assert property ($changed(processor_status_code) ||
    $changed(debug_data_nibble) |-> $fell(status_clock_out)) else $error("trace off slot");
  a_no_reserved: assert property (processor_status_code != 4'h2 &&
    processor_status_code != 4'h6) else $error("reserved code");
  a_halt_code: assert property ((core_halted && aresetn) [*3] |->
    processor_status_code == 4'hf) else $error("halt not shown");
  a_stop_code: assert property ((core_stopped && !core_halted && aresetn) [*3] |->
    processor_status_code == 4'he) else $error("stop not shown");
  a_xfer_code: assert property (capture_ready && !core_halted && !core_stopped |->
    processor_status_code == {2'b10, capture_bytes_m1}) else $error("bad transfer code");
  c_halt: cover property (processor_status_code == 4'hf);
  c_xfer4: cover property (capture_ready && capture_bytes_m1 == 2'h3);
  c_float: cover property (!output_float_request_n);
  c_trst: cover property (scan_mode && !trst_n);
endmodule
bind pstp_trace_port pstp_properties chk (.*);

// ==== pstp_regs.vh ====
// constants for the processor status trace port
`ifndef PSTP_REGS_VH
`define PSTP_REGS_VH
`define PSTP_ADDR_CTRL    4'h0
`define PSTP_ADDR_STATUS  4'h4
`define PSTP_ADDR_BKPT    4'h8
`define PSTP_CTRL_RST     2'h1
`define PSTP_BKPT_RST     4'h0
`define PSTP_RESP_OKAY    2'h0
`define PSTP_RESP_SLVERR  2'h2
`define PSTP_PST_CONT     4'h0
`define PSTP_PST_INSN     4'h1
`define PSTP_PST_USER     4'h3
`define PSTP_PST_PULSE    4'h4
`define PSTP_PST_BRANCH   4'h5
`define PSTP_PST_RTE      4'h7
`define PSTP_PST_XFER     4'h8
`define PSTP_PST_EXC      4'hc
`define PSTP_PST_EMU      4'hd
`define PSTP_PST_STOP     4'he
`define PSTP_PST_HALT     4'hf
`define PSTP_EV_INSN      0
`define PSTP_EV_USER      1
`define PSTP_EV_PULSE     2
`define PSTP_EV_BRANCH    3
`define PSTP_EV_RTE       4
`define PSTP_EV_EMU       5
`define PSTP_NUM_EV       6
`endif

// ==== pstp_trace_port.v ====
// processor status and debug data trace port with strap and float control
// Notes on behaviour
// - strap bit zero low selects background debug, high selects boundary scan
// - float request low disables every output driver but the scan data output without waiting for a clock
// - float request leaves scan data output alone; only test reset or its own scan enable floats it
// - status clock runs at the core rate, twice the input clock pin rate
// - status code and debug data are timed from the status clock, tool samples there
// - debug data nibble shows captured data values and breakpoint status
// - status code follows core execution synchronously, unrelated to bus transfers
// - codes 0000 continue, 0001 instruction begin, 0011 user mode entry
// - codes 0100 pulse or data write, 0101 branch or sync, 0111 exception return
// - codes 1000 to 1011 announce one to four byte transfers on debug data
// - codes 1100 exception, 1101 emulator entry, 1110 stopped, 1111 halted, held
// - strap bit zero picks debug or scan function on every shared pin except scan clock
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pstp_regs.vh"
module pstp_trace_port (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite register slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // device pins
  input  wire [3:0]  test_mode_strap,
  input  wire        output_float_request_n,
  input  wire        trst_n,
  // core execution events, one-cycle pulses on aclk
  input  wire [5:0]  core_event,
  input  wire        core_exc_active,
  input  wire        core_stopped,
  input  wire        core_halted,
  // captured data from the core
  input  wire        capture_valid,
  input  wire [1:0]  capture_bytes_m1,
  input  wire [31:0] capture_data,
  output reg         capture_ready,
  // shared serial output sources
  input  wire        bdm_serial_out,
  input  wire        scan_tdo,
  input  wire        scan_tdo_en,
  // trace outputs
  output reg         status_clock_out,
  output wire        status_clock_oe,
  output reg  [3:0]  processor_status_code,
  output wire        processor_status_oe,
  output reg  [3:0]  debug_data_nibble,
  output wire        debug_data_oe,
  output reg         debug_serial_out,
  output wire        debug_serial_oe,
  output reg         scan_mode
);

  reg [3:0]  strap_s1_q;
  reg [3:0]  strap_s2_q;
  reg        float_s1_q;
  reg        float_s2_q;
  reg        trst_s1_q;
  reg        trst_s2_q;
  reg        float_seen_q;
  reg [1:0]  ctrl_q;
  reg [3:0]  bkpt_q;
  reg [3:0]  aw_addr_q;
  reg        aw_have_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg        w_have_q;
  reg [5:0]  pend_q;
  reg        user_pend_q;
  reg [31:0] shift_q;
  reg [3:0]  nib_left_q;
  reg        drv_q;
  reg [3:0]  pst_d;
  reg [5:0]  take_d;
  reg        load_d;
  wire       trace_en;
  wire       bkpt_show;
  wire       slot;
  wire       wr_go;

  assign trace_en  = ctrl_q[0];
  assign bkpt_show = ctrl_q[1];
  // a new slot starts on the edge where the status clock falls, so the tool
  // sees settled values on its rising edge
  assign slot      = status_clock_out;
  assign wr_go     = aw_have_q & w_have_q & ~s_axi_bvalid;

  // the float request acts directly on the enables; the flip-flop copies
  // below only serve status readback, never the driver path
  assign status_clock_oe     = output_float_request_n;
  assign processor_status_oe = output_float_request_n;
  assign debug_data_oe       = output_float_request_n & drv_q;
  // scan output ignores the float request, obeys only its scan enable and test reset
  assign debug_serial_oe     = scan_mode ? (scan_tdo_en & trst_n)
                                         : output_float_request_n;

  // strap synchroniser keeps running in reset, which is when the mode is caught;
  // clearing it there would hide the strap from the mode flop
  always @(posedge aclk) begin
    strap_s1_q <= test_mode_strap;
    strap_s2_q <= strap_s1_q;
  end

  // pin synchronisers
  always @(posedge aclk) begin
    if (!aresetn) begin
      float_s1_q <= 1'b1;
      float_s2_q <= 1'b1;
      trst_s1_q  <= 1'b1;
      trst_s2_q  <= 1'b1;
    end else begin
      float_s1_q <= output_float_request_n;
      float_s2_q <= float_s1_q;
      trst_s1_q  <= trst_n;
      trst_s2_q  <= trst_s1_q;
    end
  end

  // mode is taken from the strap only while reset is held; straps are
  // promised stable afterwards, so no re-sampling is done
  always @(posedge aclk) begin
    if (!aresetn) begin
      scan_mode <= strap_s2_q[0];
    end
  end

  // shared serial pin: debug response or scan data by strap
  always @(posedge aclk) begin
    if (!aresetn) begin
      debug_serial_out <= 1'b0;
    end else begin
      debug_serial_out <= scan_mode ? scan_tdo : bdm_serial_out;
    end
  end

  // status clock: aclk is the core clock pair rate, divided by two here
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_clock_out <= 1'b0;
    end else begin
      status_clock_out <= ~status_clock_out;
    end
  end

  // status code choice; halt and stop outrank all, emulator entry outranks exception
  always @* begin
    pst_d  = `PSTP_PST_CONT;
    take_d = 6'h00;
    load_d = 1'b0;
    if (core_halted) begin
      pst_d = `PSTP_PST_HALT;
    end else if (core_stopped) begin
      pst_d = `PSTP_PST_STOP;
    end else if (pend_q[`PSTP_EV_EMU]) begin
      pst_d = `PSTP_PST_EMU;
      take_d[`PSTP_EV_EMU] = 1'b1;
    end else if (core_exc_active) begin
      pst_d = `PSTP_PST_EXC;
    end else if (capture_valid && nib_left_q == 4'h0 && trace_en) begin
      pst_d  = `PSTP_PST_XFER | {2'b00, capture_bytes_m1};
      load_d = 1'b1;
    end else if (pend_q[`PSTP_EV_RTE]) begin
      pst_d = `PSTP_PST_RTE;
      take_d[`PSTP_EV_RTE] = 1'b1;
    end else if (pend_q[`PSTP_EV_BRANCH]) begin
      pst_d = `PSTP_PST_BRANCH;
      take_d[`PSTP_EV_BRANCH] = 1'b1;
    end else if (pend_q[`PSTP_EV_PULSE]) begin
      pst_d = `PSTP_PST_PULSE;
      take_d[`PSTP_EV_PULSE] = 1'b1;
    end else if (pend_q[`PSTP_EV_USER]) begin
      pst_d = `PSTP_PST_USER;
      take_d[`PSTP_EV_USER] = 1'b1;
    end else if (pend_q[`PSTP_EV_INSN]) begin
      pst_d = `PSTP_PST_INSN;
      take_d[`PSTP_EV_INSN] = 1'b1;
    end
  end

  // event latches: an event arriving as its slot is taken stays pending
  always @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 6'h00;
    end else if (slot) begin
      pend_q <= (pend_q & ~take_d) | core_event;
    end else begin
      pend_q <= pend_q | core_event;
    end
  end

  // status code, data nibbles and capture handshake, one step per slot
  always @(posedge aclk) begin
    if (!aresetn) begin
      processor_status_code <= `PSTP_PST_CONT;
      debug_data_nibble     <= 4'h0;
      shift_q               <= 32'h0;
      nib_left_q            <= 4'h0;
      drv_q                 <= 1'b0;
      capture_ready         <= 1'b0;
    end else begin
      capture_ready <= 1'b0;
      if (slot) begin
        processor_status_code <= pst_d;
        drv_q                 <= 1'b1;
        if (load_d) begin
          // nibbles go out low first, two per byte
          shift_q       <= capture_data;
          nib_left_q    <= {capture_bytes_m1, 1'b0} + 4'h2;
          capture_ready <= 1'b1;
          debug_data_nibble <= bkpt_q;
        end else if (nib_left_q != 4'h0) begin
          debug_data_nibble <= shift_q[3:0];
          shift_q           <= {4'h0, shift_q[31:4]};
          nib_left_q        <= nib_left_q - 4'h1;
        end else begin
          debug_data_nibble <= bkpt_show ? bkpt_q : 4'h0;
        end
      end
    end
  end

  // sticky record of a float request, cleared by writing a one to status bit zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      float_seen_q <= 1'b0;
    end else if (!float_s2_q) begin
      float_seen_q <= 1'b1;
    end else if (wr_go && aw_addr_q == `PSTP_ADDR_STATUS && w_strb_q[0] && w_data_q[0]) begin
      float_seen_q <= 1'b0;
    end
  end

  // axi write path: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 4'h0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSTP_RESP_OKAY;
      ctrl_q        <= `PSTP_CTRL_RST;
      bkpt_q        <= `PSTP_BKPT_RST;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_have_q && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_have_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_have_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PSTP_RESP_OKAY;
        if (aw_addr_q == `PSTP_ADDR_CTRL) begin
          if (w_strb_q[0]) ctrl_q <= w_data_q[1:0];
        end else if (aw_addr_q == `PSTP_ADDR_BKPT) begin
          if (w_strb_q[0]) bkpt_q <= w_data_q[3:0];
        end else if (aw_addr_q != `PSTP_ADDR_STATUS) begin
          s_axi_bresp <= `PSTP_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read path, one answer at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `PSTP_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `PSTP_RESP_OKAY;
        if (s_axi_araddr == `PSTP_ADDR_CTRL) begin
          s_axi_rdata <= {30'h0, ctrl_q};
        end else if (s_axi_araddr == `PSTP_ADDR_STATUS) begin
          s_axi_rdata <= {16'h0, processor_status_code, strap_s2_q,
                          2'h0, nib_left_q != 4'h0, trst_s2_q,
                          float_s2_q, scan_mode, 1'b0, float_seen_q};
        end else if (s_axi_araddr == `PSTP_ADDR_BKPT) begin
          s_axi_rdata <= {28'h0, bkpt_q};
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `PSTP_RESP_SLVERR;
        end
      end
    end
  end

endmodule

// ==== pstp_trace_tool.sv ====
// trace tool model that samples the status and debug data pins
`timescale 1ns/1ps
module pstp_trace_tool (
  // trace pins
  input  logic        status_clock_out,
  input  logic [3:0]  processor_status_code,
  input  logic        processor_status_oe,
  input  logic [3:0]  debug_data_nibble,
  // what the tool has seen
  output logic [3:0]  seen_code = 4'h0,
  output logic [3:0]  xfer_code = 4'h0,
  output logic [31:0] word = 32'h0,
  output logic [3:0]  left = 4'h0
);
  logic [2:0] pos = 3'h0;
  // sample on the rising status clock only; a floated bus carries nothing
  always @(posedge status_clock_out) begin
    if (processor_status_oe) begin
      seen_code <= processor_status_code;
      if (left != 4'h0) begin
        word[pos * 4 +: 4] <= debug_data_nibble;
        pos <= pos + 3'h1;
        left <= left - 4'h1;
      end else if (processor_status_code[3:2] == 2'b10) begin
        xfer_code <= processor_status_code;
        word <= 32'h0;
        pos <= 3'h0;
        left <= {1'b0, processor_status_code[1:0], 1'b0} + 4'h2;
      end
    end
  end
endmodule

// ==== test_processor_status_trace_port.sv ====
// self-checking bench for the processor status trace port
`timescale 1ns/1ps
`define check(n, g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module test_processor_status_trace_port;
  logic        aclk = 0, aresetn = 0, trst_n = 1, output_float_request_n = 1;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf, test_mode_strap = 0;
  logic [31:0] s_axi_wdata = 0, capture_data = 0, s_axi_rdata, q, word;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, capture_valid = 0;
  logic [5:0]  core_event = 0;
  logic        core_exc_active = 0, core_stopped = 0, core_halted = 0;
  logic        bdm_serial_out = 0, scan_tdo = 0, scan_tdo_en = 0;
  logic [1:0]  capture_bytes_m1 = 0, s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        capture_ready, status_clock_out, status_clock_oe, processor_status_oe;
  logic        debug_data_oe, debug_serial_out, debug_serial_oe, scan_mode;
  logic [3:0]  processor_status_code, debug_data_nibble, seen_code, xfer_code, left;
  logic [3:0]  ev_code [6] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'hd};
  int          miscompares = 0, comparisons = 0;
  pstp_trace_port dut (.*);
  pstp_trace_tool tool (.*);
  initial forever #25 aclk = ~aclk;
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // write both halves at once, release each on its own ready
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    `check("bresp", s_axi_bresp, r)
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 0;
    `check("rresp", s_axi_rresp, r)
  endtask
  // the tool gets a bounded number of slots to report a code
  task automatic see(input logic [3:0] e);
    for (int i = 0; i < 12 && seen_code !== e; i++) @(posedge aclk);
    `check("status code", seen_code, e)
  endtask
  task automatic xfer(input logic [1:0] m);
    {capture_bytes_m1, capture_data, capture_valid} <= {m, 32'h87654321, 1'b1};
    for (int i = 0; i < 40 && capture_ready !== 1'b1; i++) @(posedge aclk);
    capture_valid <= 0;
    for (int i = 0; i < 40 && (i < 4 || left !== 4'h0); i++) @(posedge aclk);
    `check("transfer code", xfer_code, {2'b10, m})
    `check("data", word, 32'h87654321 & ~(32'hffffffff << (8 * (m + 1))))
    @(posedge aclk);
    `check("bkpt nibble", debug_data_nibble, 4'ha)
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    bdm_serial_out <= 1;
    axr(4'h0, q, 2'h0);
    `check("ctrl reset", q, 32'h1)
    axr(4'h8, q, 2'h0);
    `check("bkpt reset", q, 32'h0)
    axr(4'hc, q, 2'h2);
    `check("unmapped data", q, 32'h0)
    axw(4'hc, 32'h5, 2'h2);
    axw(4'h0, 32'h3, 2'h0);
    axw(4'h8, 32'ha, 2'h0);
    s_axi_wstrb <= 4'h0;
    axw(4'h8, 32'h5, 2'h0);
    s_axi_wstrb <= 4'hf;
    axr(4'h8, q, 2'h0);
    `check("bkpt", q, 32'ha)
    `check("bdm mode", scan_mode, 1'b0)
    `check("bdm serial", {debug_serial_oe, debug_serial_out}, 2'b11)
    $display("register test done");
    for (int i = 0; i < 6; i++) begin
      core_event <= 6'h1 << i;
      @(posedge aclk);
      core_event <= 6'h0;
      see(ev_code[i]);
    end
    see(4'h0);
    core_exc_active <= 1;
    see(4'hc);
    core_halted <= 1;
    see(4'hf);
    core_halted <= 0;
    core_stopped <= 1;
    see(4'he);
    core_stopped <= 0;
    core_exc_active <= 0;
    see(4'h0);
    $display("status code test done");
    for (int m = 0; m < 4; m++) xfer(m[1:0]);
    $display("transfer test done");
    output_float_request_n <= 0;
    #1;
    `check("float oe", {status_clock_oe, processor_status_oe, debug_data_oe}, 3'h0)
    repeat (4) @(posedge aclk);
    output_float_request_n <= 1;
    axr(4'h4, q, 2'h0);
    `check("float seen", q[0], 1'b1)
    axw(4'h4, 32'h1, 2'h0);
    axr(4'h4, q, 2'h0);
    `check("float cleared", q[0], 1'b0)
    $display("float test done");
    aresetn <= 0;
    @(posedge aclk);
    test_mode_strap <= 4'h1;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    output_float_request_n <= 0;
    scan_tdo_en <= 1;
    scan_tdo <= 1;
    repeat (3) @(posedge aclk);
    `check("scan mode", scan_mode, 1'b1)
    `check("scan out", {debug_serial_oe, debug_serial_out}, 2'b11)
    trst_n <= 0;
    #1;
    `check("trst oe", debug_serial_oe, 1'b0)
    repeat (2) @(posedge aclk);
    $display("scan test done");
    summarize();
  end
endmodule
